// ### logic/pts_defs.svh
// Purpose: Register map, field layout and counts of the period timer
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Only constants live here
`ifndef PTS_DEFS_SVH
`define PTS_DEFS_SVH

`define PTS_IDX_CONTROL      8'h12
`define PTS_IDX_COUNT        8'h11
`define PTS_IDX_PERIOD       8'h92
`define PTS_IDX_FLAGS        8'h0c
`define PTS_ADDR_W           10
`define PTS_CTL_RESET        7'h00
`define PTS_COUNT_RESET      8'h00
`define PTS_PERIOD_RESET     8'hff
`define PTS_CTL_PRE_LSB      0
`define PTS_CTL_PRE_MSB      1
`define PTS_CTL_RUN_BIT      2
`define PTS_CTL_POST_LSB     3
`define PTS_CTL_POST_MSB     6
`define PTS_FLAG_MATCH_BIT   1
`define PTS_PRE_DIV4_LAST    4'h3
`define PTS_PRE_DIV16_LAST   4'hf
`define PTS_FOSC_DIV_LAST    2'h3

`endif

// ### logic/pts_pkg.sv
// Purpose: Types shared by the period timer files
// Assumes: Constants come from pts_defs.svh
// Notes:   Prescale codes follow the control field encoding
package pts_pkg;
  typedef enum logic [1:0] {
    PTS_PRE_DIV1  = 2'b00,
    PTS_PRE_DIV4  = 2'b01,
    PTS_PRE_DIV16 = 2'b10
  } pts_pre_t;
endpackage

// ### logic/pts_scaler.sv
// Purpose: Programmable divide-by-N event counter
// Assumes: Enable pulses arrive on clk_sys, one cycle each
// Notes:   Pulses out on the event that completes last_val+1 events
`timescale 1ns/1ps
module pts_scaler #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clear,
  input  wire logic             event_in,
  input  wire logic [WIDTH-1:0] last_val,
  output logic                  tick
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             at_last;

  assign at_last = (cnt_q >= last_val);
  assign tick    = event_in && at_last && !clear;

  always_comb begin
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = '0;
    end else if (event_in) begin
      cnt_d = at_last ? '0 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ### logic/pts_timer.sv
// Purpose: Period timer with prescaler, period match and postscaler
// Assumes: APB slave, clk_sys is the oscillator clock
// Notes:   Instruction rate is clk_sys divided by four
// Functional notes
// - Count register is read/write and clears to zero on any reset.
// - Timer input is oscillator/4 through a 1, 4 or 16 prescaler.
// - Prescale code 00 divides by 1, 01 by 4, 1x by 16.
// - Match pulses pass a 4-bit postscaler setting the latched match flag.
// - Postscale code N divides by N+1, from 1 to 16.
// - Count or control writes, and reset, clear both scaler counters.
// - A control write leaves the count value unchanged.
// - Control bit 2 runs the timer; cleared, counting stops.
// - Match output is offered as a PWM time base.
// - Match happens when count equals the 8-bit period register.
// - Count and period are 8-bit, both readable and writable.
`timescale 1ns/1ps
`include "pts_defs.svh"
module pts_timer #(
  parameter int CNT_W = 8
) (
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`PTS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        pwm_time_base,
  output logic                        match_irq_flag
);
  logic [6:0]       timer_control_q;
  logic [CNT_W-1:0] timer_count_q;
  logic [CNT_W-1:0] timer_count_d;
  logic [CNT_W-1:0] period_value_q;
  logic             match_irq_flag_q;
  logic [1:0]       fosc_div_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;

  function automatic logic [`PTS_ADDR_W-1:0] reg_addr(
    input logic [7:0] idx
  );
    reg_addr = {idx, 2'b00};
  endfunction

  // Bus decode
  wire access_en = psel && penable;
  wire wr_en     = access_en && pwrite && pstrb[0];
  wire hit_ctl   = (paddr == reg_addr(`PTS_IDX_CONTROL));
  wire hit_cnt   = (paddr == reg_addr(`PTS_IDX_COUNT));
  wire hit_per   = (paddr == reg_addr(`PTS_IDX_PERIOD));
  wire hit_flg   = (paddr == reg_addr(`PTS_IDX_FLAGS));
  wire hit_any   = hit_ctl || hit_cnt || hit_per || hit_flg;
  wire wr_ctl    = wr_en && hit_ctl;
  wire wr_cnt    = wr_en && hit_cnt;
  wire wr_per    = wr_en && hit_per;
  wire wr_flg    = wr_en && hit_flg;

  // Fields
  wire [1:0] pre_sel  =
    timer_control_q[`PTS_CTL_PRE_MSB:`PTS_CTL_PRE_LSB];
  wire [3:0] post_sel =
    timer_control_q[`PTS_CTL_POST_MSB:`PTS_CTL_POST_LSB];
  wire       run      = timer_control_q[`PTS_CTL_RUN_BIT];

  // Instruction clock enable, oscillator over four
  wire instr_tick = (fosc_div_q == `PTS_FOSC_DIV_LAST);

  // Prescale decode; any code with the upper bit set is divide-by-16
  wire [3:0] pre_last =
    pre_sel[1]                              ? `PTS_PRE_DIV16_LAST :
    (pre_sel == pts_pkg::PTS_PRE_DIV4)      ? `PTS_PRE_DIV4_LAST  :
                                              4'h0;

  // Scaler counters clear on count or control write
  wire scaler_clr = wr_ctl || wr_cnt;

  wire pre_tick;
  wire match_now = (timer_count_q == period_value_q);
  wire match_tick = pre_tick && match_now && !wr_cnt;
  wire post_tick;

  pts_scaler #(
    .WIDTH (4)
  ) u_prescaler (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .clear    (scaler_clr),
    .event_in (instr_tick && run),
    .last_val (pre_last),
    .tick     (pre_tick)
  );

  pts_scaler #(
    .WIDTH (4)
  ) u_postscaler (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .clear    (scaler_clr),
    .event_in (match_tick),
    .last_val (post_sel),
    .tick     (post_tick)
  );

  always_comb begin
    timer_count_d = timer_count_q;
    if (wr_cnt) begin
      timer_count_d = pwdata[CNT_W-1:0];
    end else if (pre_tick) begin
      if (match_now) begin
        timer_count_d = '0;
      end else begin
        timer_count_d = timer_count_q + 1'b1;
      end
    end
  end

  // Read mux; bit 7 of control reads zero
  wire [31:0] rd_mux =
    hit_ctl ? {25'h0, timer_control_q} :
    hit_cnt ? {{(32-CNT_W){1'b0}}, timer_count_q} :
    hit_per ? {{(32-CNT_W){1'b0}}, period_value_q} :
    hit_flg ? {30'h0, match_irq_flag_q, 1'b0} :
              32'h0;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fosc_div_q <= 2'h0;
    end else begin
      fosc_div_q <= fosc_div_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      timer_control_q <= `PTS_CTL_RESET;
      timer_count_q   <= `PTS_COUNT_RESET;
      period_value_q  <= `PTS_PERIOD_RESET;
    end else begin
      // Control write keeps the count untouched
      if (wr_ctl) begin
        timer_control_q <= pwdata[6:0];
      end
      if (wr_per) begin
        period_value_q <= pwdata[CNT_W-1:0];
      end
      timer_count_q <= timer_count_d;
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      match_irq_flag_q <= 1'b0;
    end else if (post_tick) begin
      match_irq_flag_q <= 1'b1;
    end else if (wr_flg) begin
      match_irq_flag_q <= pwdata[`PTS_FLAG_MATCH_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q  <= pwrite ? 32'h0 : rd_mux;
      pslverr_q <= !hit_any;
    end
  end

  assign prdata         = prdata_q;
  assign pready         = 1'b1;
  assign pslverr        = access_en && pslverr_q;
  assign pwm_time_base  = match_tick;
  assign match_irq_flag = match_irq_flag_q;
endmodule

// ### sim/pts_timer_checker.sv
// Purpose: Port checks for pts_timer
// Assumes: Byte addresses, control at 0x48, flags at 0x30
// Notes:   Bound to every pts_timer instance
`timescale 1ns/1ps
module pts_checker (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pwm_time_base,
  input wire logic        match_irq_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire acc = psel && penable;
  wire flw = acc && pwrite && paddr == 10'h030;
  AST_READY: assert property (acc |-> pready)
    else $error("no ready in access");
  AST_ERR_IDLE: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  AST_ERR_MAP: assert property (acc && paddr == 10'h3fc |-> pslverr)
    else $error("unmapped access not refused");
  AST_CNT_OK: assert property (acc && paddr == 10'h044 |-> !pslverr)
    else $error("count access refused");
  AST_UPPER: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_CTL_B7: assert property (acc && !pwrite && paddr == 10'h048
    |-> !prdata[7])
    else $error("control bit 7 reads one");
  AST_PULSE: assert property (pwm_time_base |=> !pwm_time_base[*3])
    else $error("match pulses too close");
  AST_FLAG_HOLD: assert property (match_irq_flag && !flw |=> match_irq_flag)
    else $error("flag dropped without clear");
  AST_FLAG_SET: assert property ($rose(match_irq_flag)
    |-> $past(pwm_time_base) || $past(flw))
    else $error("flag set without cause");
  cover property (pwm_time_base);
  cover property ($rose(match_irq_flag));
  cover property (pslverr);
endmodule
bind pts_timer pts_checker u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pwm_time_base(pwm_time_base),
  .match_irq_flag(match_irq_flag));

// ### sim/tb_top.sv
// Purpose: Self-checking bench for pts_timer
// Assumes: Zero-wait APB slave, pwm and flag sampled on falling edges, read data and error on rising edges
// Notes:   Intervals are counted in clk_sys cycles
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  localparam logic [9:0] CTL = 10'h048, CNT = 10'h044;
  localparam logic [9:0] PER = 10'h248, FLG = 10'h030;
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        pwm, flag, err;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, nn;
  int          bad_count, n_compared, cyc, n, k;
  pts_timer DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_time_base(pwm), .match_irq_flag(flag));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask
  task automatic wp;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (pwm !== 1'b1 && n < 2000);
  endtask
  task automatic t_regs;
    rdchk(CTL, 8'h00); rdchk(CNT, 8'h00);
    rdchk(PER, 8'hff); rdchk(FLG, 8'h00);
    apb(1'b1, PER, 8'h5a); rdchk(PER, 8'h5a);
    apb(1'b1, CNT, 8'h33); rdchk(CNT, 8'h33);
    apb(1'b1, CTL, 8'hfb); rdchk(CTL, 8'h7b);
    apb(1'b0, 10'h3fc, 8'h00);
    `CHK(err, 1'b1)
    $display("test regs done");
  endtask
  task automatic t_keep;
    apb(1'b1, CNT, 8'h07); apb(1'b1, CTL, 8'h03);
    rdchk(CNT, 8'h07);
    repeat (40) @(negedge clk_sys);
    rdchk(CNT, 8'h07);
    $display("test keep done");
  endtask
  task automatic t_pre;
    apb(1'b1, CNT, 8'h00); apb(1'b1, PER, 8'h02);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, CTL, {5'h00, 1'b1, c[1:0]});
      wp; wp;
      `CHK(n, 12 * (c == 0 ? 1 : c == 1 ? 4 : 16))
    end
    $display("test prescale done");
  endtask
  task automatic t_post;
    apb(1'b1, PER, 8'h00);
    for (int i = 0; i < 3; i++) begin
      nn = (i == 2) ? 4'hf : i[3:0];
      apb(1'b1, CTL, 8'h00); apb(1'b1, FLG, 8'h00);
      @(negedge clk_sys);
      `CHK(flag, 1'b0)
      apb(1'b1, CTL, {1'b0, nn, 3'b100});
      k = 0;
      do begin wp; k++; @(negedge clk_sys); end while (flag !== 1'b1 && k < 20);
      `CHK(k, nn + 1)
    end
    $display("test postscale done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin bad_count++; tally_and_finish; end
  end
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 10'h0; pwdata = 32'h0; pstrb = 4'hf;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs; t_keep; t_pre; t_post;
    tally_and_finish;
  end
endmodule
